// File: common/rdc_pkg.sv
// Constants and types shared by the reader direct command decoder.
package rdc_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_SET_DEFAULT   = 8'hc1;
	localparam logic [7:0] CMD_CLEAR_A       = 8'hc2;
	localparam logic [7:0] CMD_CLEAR_B       = 8'hc3;
	localparam logic [7:0] CMD_UNMASK_RX     = 8'hd1;
	localparam logic [7:0] CMD_MEAS_AMPL     = 8'hd3;
	localparam logic [7:0] CMD_SQUELCH       = 8'hd4;
	localparam logic [7:0] CMD_RESET_GAIN    = 8'hd5;
	localparam logic [7:0] CMD_ADJ_REG       = 8'hd6;
	localparam logic [7:0] CMD_CAL_MOD       = 8'hd7;
	localparam logic [7:0] CMD_CAL_ANT       = 8'hd8;
	localparam logic [7:0] CMD_MEAS_PHASE    = 8'hd9;
	localparam logic [7:0] CMD_CLEAR_RSSI    = 8'hda;
	localparam logic [7:0] CMD_TRANSPARENT   = 8'hdc;
	localparam logic [7:0] CMD_CAL_CAP       = 8'hdd;
	localparam logic [7:0] CMD_MEAS_CAP      = 8'hde;
	localparam logic [7:0] CMD_MEAS_SUPPLY   = 8'hdf;
	localparam logic [7:0] CMD_START_GPT     = 8'he0;
	localparam logic [7:0] CMD_START_WUT     = 8'he1;
	localparam logic [7:0] CMD_START_MRT     = 8'he2;
	localparam logic [7:0] CMD_START_NRT     = 8'he3;
	localparam logic [7:0] CMD_TEST_ACCESS   = 8'hfc;

	// ----------------------------------------
	// Measurement and calibration unit indices
	// ----------------------------------------
	localparam int          UNIT_N           = 8;
	localparam logic [2:0]  UNIT_AMPL        = 3'h0;
	localparam logic [2:0]  UNIT_REG         = 3'h1;
	localparam logic [2:0]  UNIT_MOD         = 3'h2;
	localparam logic [2:0]  UNIT_ANT         = 3'h3;
	localparam logic [2:0]  UNIT_PHASE       = 3'h4;
	localparam logic [2:0]  UNIT_CAP_CAL     = 3'h5;
	localparam logic [2:0]  UNIT_CAP_MEAS    = 3'h6;
	localparam logic [2:0]  UNIT_SUPPLY      = 3'h7;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_OP_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_REG_CTRL     = 8'h01;
	localparam logic [7:0] ADDR_CAP_CTRL     = 8'h02;
	localparam logic [7:0] ADDR_TMR_CTRL     = 8'h03;
	localparam logic [7:0] ADDR_RX_CONF4     = 8'h04;
	localparam logic [7:0] ADDR_MODE         = 8'h05;
	localparam logic [7:0] ADDR_STATUS       = 8'h06;
	localparam logic [7:0] ADDR_LAST_CMD     = 8'h07;
	localparam logic [7:0] ADDR_GAIN         = 8'h08;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_EN                    = 7;
	localparam int BIT_RX_EN                 = 6;
	localparam int BIT_TX_EN                 = 3;
	localparam int BIT_REG_S                 = 7;
	localparam int BIT_CS_MCAL               = 0;
	localparam int BIT_NRT_EMV               = 0;
	localparam int BIT_INIT_TARGET           = 0;
	localparam int BIT_WAKEUP_MODE           = 1;
	localparam int BIT_ST_BUSY               = 0;
	localparam int BIT_ST_TRANSPARENT        = 1;
	localparam int BIT_ST_TEST_ACCESS        = 2;
	localparam int BIT_ST_REJECTED           = 3;
	localparam int BIT_ST_XTAL_OK            = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_OP_CTRL       = 8'h00;
	localparam logic [7:0] RST_REG_CTRL      = 8'h00;
	localparam logic [7:0] RST_CAP_CTRL      = 8'h00;
	localparam logic [7:0] RST_TMR_CTRL      = 8'h00;
	localparam logic [7:0] RST_RX_CONF4      = 8'h00;
	localparam logic [7:0] RST_MODE          = 8'h00;
	localparam logic [7:0] RST_GAIN          = 8'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {
		RDC_IDLE,
		RDC_BUSY
	} rdc_state_type;

endpackage

// File: hw/rdc_decoder.sv
// Direct command decoder and executor of the reader front end.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - Commands run only when all their required operation-control bits are set.
// RQ2 - D1 resumes receive processing over mask timer; needs en and rx_en.
// RQ3 - D3 measures receive amplitude into converter output, interrupts when done; en.
// RQ4 - D4 reduces receive gain from present noise; needs en and rx_en.
// RQ5 - D5 drops squelch reduction and loads manual gain from receiver config 4.
// RQ6 - D6 trims regulators and interrupts; rejected while external regulator select set.
// RQ7 - D7 enables transmitter, calibrates modulation depth, interrupts at completion.
// RQ8 - D8 tunes trim capacitors to antenna resonance, then interrupts.
// RQ9 - D9 measures transmit-to-receive phase difference, interrupts; needs en.
// RQ10 - DA clears RSSI result and restarts measurement; no interrupt.
// RQ11 - DC with en enters transparent mode; no interrupt.
// RQ12 - DD calibrates capacitive sensor in any mode while manual calibration bit clear.
// RQ13 - DE measures capacitance in any mode and interrupts when done.
// RQ14 - E2 starts mask-receive timer only in initial active-target mode.
// RQ15 - FC enables test register writes in all modes; other codes unused.
// RQ16 - Set default restores power-up register values and drops calibration results.
// RQ17 - Set default keeps both IO configuration and operation control registers.
// RQ18 - Set default with en clear leaves FIFO and FIFO status alone.
// RQ19 - Set default gives no interrupt; controller must not chain behind it.
// RQ20 - Clear aborts transfer, empties FIFO, resets FIFO, collision, interrupt status.
// RQ21 - Clear stops timers except wake-up; no-response timer kept when persist set.
// RQ22 - Controller issues clear before loading FIFO for framed transmissions.
// RQ23 - Clear is accepted only with en set and oscillator stable.
// RQ24 - C1 is set default; C2 and C3 are both clear.
// RQ25 - Unused or unqualified codes are ignored with no state change or interrupt; here they set the rejected status bit.
module rdc_decoder
	import rdc_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk_i,
	input  wire logic              arst_n_i,
	// Register port
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [7:0]        reg_rdata_o,
	// Command port
	input  wire logic              cmd_valid_i,
	input  wire logic [7:0]        cmd_code_i,
	output logic                   cmd_chain_ok_o,
	output logic                   cmd_busy_o,
	output logic                   cmd_done_irq_o,
	// Analog status
	input  wire logic              xtal_stable_i,
	input  wire logic [7:0]        noise_level_i,
	// Measurement and calibration units
	output logic      [UNIT_N-1:0] unit_start_o,
	input  wire logic [UNIT_N-1:0] unit_done_i,
	output logic                   tx_activate_o,
	output logic                   results_discard_o,
	// Receive path
	output logic                   rx_unmask_o,
	output logic                   rssi_restart_o,
	output logic      [7:0]        rx_gain_red_o,
	// Framing and FIFO
	output logic                   txrx_abort_o,
	output logic                   fifo_clear_o,
	output logic                   irq_regs_clear_o,
	output logic                   set_default_o,
	output logic                   transparent_o,
	output logic                   test_access_o,
	// Timers
	output logic                   gpt_start_o,
	output logic                   wut_start_o,
	output logic                   mrt_start_o,
	output logic                   nrt_start_o,
	output logic                   gpt_stop_o,
	output logic                   mrt_stop_o,
	output logic                   nrt_stop_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		rdc_state_type     st;
		logic [2:0]        xs;
		logic              xtal_ok;
		logic [7:0]        op_ctrl;
		logic [7:0]        reg_ctrl;
		logic [7:0]        cap_ctrl;
		logic [7:0]        tmr_ctrl;
		logic [7:0]        rx_conf4;
		logic [7:0]        mode;
		logic [7:0]        gain_red;
		logic [7:0]        last_cmd;
		logic              transparent;
		logic              test_access;
		logic              rejected;
		logic              chain_ok;
		logic [2:0]        unit;
		logic [UNIT_N-1:0] unit_start;
		logic              tx_act;
		logic              done_irq;
		logic              discard;
		logic              unmask;
		logic              rssi;
		logic              abort;
		logic              fifo_clr;
		logic              irq_clr;
		logic              set_def;
		logic              gpt_start;
		logic              wut_start;
		logic              mrt_start;
		logic              nrt_start;
		logic              gpt_stop;
		logic              mrt_stop;
		logic              nrt_stop;
		logic [7:0]        rdata;
	} rdc_regs_type;

	rdc_regs_type s_r;
	rdc_regs_type s_nxt;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic       en;
	logic       rx_en;
	logic       accept;
	logic       known;
	logic       chain;
	logic       uses_unit;
	logic [2:0] unit_sel;

	assign en    = s_r.op_ctrl[BIT_EN];
	assign rx_en = s_r.op_ctrl[BIT_RX_EN];

	always_comb begin
		known     = 1'b1;
		accept    = 1'b0;
		chain     = 1'b0;
		uses_unit = 1'b1;
		unit_sel  = UNIT_AMPL;
		unique case (cmd_code_i)
			CMD_SET_DEFAULT: accept = 1'b1; // RQ16 RQ19 RQ24
			CMD_CLEAR_A, CMD_CLEAR_B: begin
				accept = en && s_r.xtal_ok; // RQ23 RQ24
				chain  = 1'b1;
			end
			CMD_UNMASK_RX: begin
				accept = en && rx_en; // RQ1 RQ2
				chain  = 1'b1;
			end
			CMD_MEAS_AMPL, CMD_CAL_MOD, CMD_CAL_ANT,
			CMD_MEAS_PHASE, CMD_MEAS_SUPPLY: accept = en; // RQ3 RQ7 RQ8 RQ9
			CMD_SQUELCH: accept = en && rx_en; // RQ4
			CMD_RESET_GAIN: accept = en; // RQ5
			CMD_ADJ_REG: accept = en && !s_r.reg_ctrl[BIT_REG_S]; // RQ6
			CMD_CLEAR_RSSI, CMD_START_GPT: begin
				accept = en; // RQ10
				chain  = 1'b1;
			end
			CMD_TRANSPARENT: accept = en; // RQ11
			CMD_CAL_CAP: accept = !s_r.cap_ctrl[BIT_CS_MCAL]; // RQ12
			CMD_MEAS_CAP: accept = 1'b1; // RQ13
			CMD_START_WUT: begin
				accept = !s_r.mode[BIT_WAKEUP_MODE];
				chain  = 1'b1;
			end
			CMD_START_MRT: begin
				accept = s_r.mode[BIT_INIT_TARGET]; // RQ14
				chain  = 1'b1;
			end
			CMD_START_NRT: begin
				accept = en && rx_en;
				chain  = 1'b1;
			end
			CMD_TEST_ACCESS: begin
				accept = 1'b1; // RQ15
				chain  = 1'b1;
			end
			default: known = 1'b0; // RQ15 RQ25
		endcase
		unique case (cmd_code_i)
			CMD_MEAS_AMPL:   unit_sel = UNIT_AMPL;
			CMD_ADJ_REG:     unit_sel = UNIT_REG;
			CMD_CAL_MOD:     unit_sel = UNIT_MOD; // RQ7
			CMD_CAL_ANT:     unit_sel = UNIT_ANT; // RQ8
			CMD_MEAS_PHASE:  unit_sel = UNIT_PHASE;
			CMD_CAL_CAP:     unit_sel = UNIT_CAP_CAL;
			CMD_MEAS_CAP:    unit_sel = UNIT_CAP_MEAS;
			CMD_MEAS_SUPPLY: unit_sel = UNIT_SUPPLY;
			default:         uses_unit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt            = s_r;
		s_nxt.unit_start = '0;
		s_nxt.done_irq   = 1'b0;
		s_nxt.discard    = 1'b0;
		s_nxt.unmask     = 1'b0;
		s_nxt.rssi       = 1'b0;
		s_nxt.abort      = 1'b0;
		s_nxt.fifo_clr   = 1'b0;
		s_nxt.irq_clr    = 1'b0;
		s_nxt.set_def    = 1'b0;
		s_nxt.gpt_start  = 1'b0;
		s_nxt.wut_start  = 1'b0;
		s_nxt.mrt_start  = 1'b0;
		s_nxt.nrt_start  = 1'b0;
		s_nxt.gpt_stop   = 1'b0;
		s_nxt.mrt_stop   = 1'b0;
		s_nxt.nrt_stop   = 1'b0;
		s_nxt.rdata      = 8'h00;

		// Oscillator flag follows once the second and third stages agree.
		s_nxt.xs = {s_r.xs[1:0], xtal_stable_i};
		if (s_r.xs[1] == s_r.xs[2]) begin
			s_nxt.xtal_ok = s_r.xs[2];
		end

		// Register reads answer in the next cycle only.
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_OP_CTRL:  s_nxt.rdata = s_r.op_ctrl;
				ADDR_REG_CTRL: s_nxt.rdata = s_r.reg_ctrl;
				ADDR_CAP_CTRL: s_nxt.rdata = s_r.cap_ctrl;
				ADDR_TMR_CTRL: s_nxt.rdata = s_r.tmr_ctrl;
				ADDR_RX_CONF4: s_nxt.rdata = s_r.rx_conf4;
				ADDR_MODE:     s_nxt.rdata = s_r.mode;
				ADDR_STATUS: begin
					s_nxt.rdata[BIT_ST_BUSY]        = (s_r.st == RDC_BUSY);
					s_nxt.rdata[BIT_ST_TRANSPARENT] = s_r.transparent;
					s_nxt.rdata[BIT_ST_TEST_ACCESS] = s_r.test_access;
					s_nxt.rdata[BIT_ST_REJECTED]    = s_r.rejected;
					s_nxt.rdata[BIT_ST_XTAL_OK]     = s_r.xtal_ok;
				end
				ADDR_LAST_CMD: s_nxt.rdata = s_r.last_cmd;
				ADDR_GAIN:     s_nxt.rdata = s_r.gain_red;
				default:       s_nxt.rdata = 8'h00;
			endcase
		end

		if (reg_wr_i) begin
			unique case (reg_addr_i)
				ADDR_OP_CTRL:  s_nxt.op_ctrl  = reg_wdata_i;
				ADDR_REG_CTRL: s_nxt.reg_ctrl = reg_wdata_i;
				ADDR_CAP_CTRL: s_nxt.cap_ctrl = reg_wdata_i;
				ADDR_TMR_CTRL: s_nxt.tmr_ctrl = reg_wdata_i;
				ADDR_RX_CONF4: s_nxt.rx_conf4 = reg_wdata_i;
				ADDR_MODE:     s_nxt.mode     = reg_wdata_i;
				default: ;
			endcase
		end

		// A running unit ends with its done pulse and the completion interrupt.
		if (s_r.st == RDC_BUSY && unit_done_i[s_r.unit]) begin
			s_nxt.st       = RDC_IDLE;
			s_nxt.tx_act   = 1'b0;
			s_nxt.done_irq = 1'b1; // RQ3 RQ6 RQ7 RQ8 RQ9 RQ12 RQ13
		end

		// While a unit runs only set default is taken; it abandons the unit.
		if (cmd_valid_i && known && accept &&
			(s_r.st == RDC_IDLE || cmd_code_i == CMD_SET_DEFAULT)) begin
			s_nxt.last_cmd = cmd_code_i;
			s_nxt.rejected = 1'b0;
			s_nxt.chain_ok = chain;
			if (uses_unit) begin
				s_nxt.st                   = RDC_BUSY;
				s_nxt.unit                 = unit_sel;
				s_nxt.unit_start[unit_sel] = 1'b1;
				s_nxt.tx_act               = (unit_sel == UNIT_MOD); // RQ7
			end
			unique case (cmd_code_i)
				CMD_SET_DEFAULT: begin
					s_nxt.st          = RDC_IDLE;
					s_nxt.tx_act      = 1'b0;
					s_nxt.done_irq    = 1'b0; // RQ19
					s_nxt.set_def     = 1'b1;
					s_nxt.discard     = 1'b1; // RQ16
					s_nxt.reg_ctrl    = RST_REG_CTRL; // RQ16
					s_nxt.cap_ctrl    = RST_CAP_CTRL;
					s_nxt.tmr_ctrl    = RST_TMR_CTRL;
					s_nxt.rx_conf4    = RST_RX_CONF4;
					s_nxt.mode        = RST_MODE;
					s_nxt.gain_red    = RST_GAIN;
					s_nxt.transparent = 1'b0;
					s_nxt.test_access = 1'b0;
					s_nxt.op_ctrl     = s_r.op_ctrl; // RQ17
					s_nxt.fifo_clr    = en; // RQ18
				end
				CMD_CLEAR_A, CMD_CLEAR_B: begin
					s_nxt.abort    = 1'b1; // RQ20
					s_nxt.fifo_clr = 1'b1;
					s_nxt.irq_clr  = 1'b1;
					s_nxt.gpt_stop = 1'b1; // RQ21
					s_nxt.mrt_stop = 1'b1;
					s_nxt.nrt_stop = !s_r.tmr_ctrl[BIT_NRT_EMV]; // RQ21
				end
				CMD_UNMASK_RX:   s_nxt.unmask      = 1'b1; // RQ2
				CMD_SQUELCH:     s_nxt.gain_red    = noise_level_i; // RQ4
				CMD_RESET_GAIN:  s_nxt.gain_red    = s_r.rx_conf4; // RQ5
				CMD_CLEAR_RSSI:  s_nxt.rssi        = 1'b1; // RQ10
				CMD_TRANSPARENT: s_nxt.transparent = 1'b1; // RQ11
				CMD_START_GPT:   s_nxt.gpt_start   = 1'b1;
				CMD_START_WUT:   s_nxt.wut_start   = 1'b1;
				CMD_START_MRT:   s_nxt.mrt_start   = 1'b1; // RQ14
				CMD_START_NRT:   s_nxt.nrt_start   = 1'b1;
				CMD_TEST_ACCESS: s_nxt.test_access = 1'b1; // RQ15
				default: ;
			endcase
		end else if (cmd_valid_i) begin
			s_nxt.rejected = 1'b1; // RQ1 RQ25
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r          <= '0;
			s_r.st       <= RDC_IDLE;
			s_r.op_ctrl  <= RST_OP_CTRL;
			s_r.reg_ctrl <= RST_REG_CTRL;
			s_r.cap_ctrl <= RST_CAP_CTRL;
			s_r.tmr_ctrl <= RST_TMR_CTRL;
			s_r.rx_conf4 <= RST_RX_CONF4;
			s_r.mode     <= RST_MODE;
			s_r.gain_red <= RST_GAIN;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_o       = s_r.rdata;
	assign cmd_chain_ok_o    = s_r.chain_ok;
	assign cmd_busy_o        = (s_r.st == RDC_BUSY);
	assign cmd_done_irq_o    = s_r.done_irq;
	assign unit_start_o      = s_r.unit_start;
	assign tx_activate_o     = s_r.tx_act;
	assign results_discard_o = s_r.discard;
	assign rx_unmask_o       = s_r.unmask;
	assign rssi_restart_o    = s_r.rssi;
	assign rx_gain_red_o     = s_r.gain_red;
	assign txrx_abort_o      = s_r.abort;
	assign fifo_clear_o      = s_r.fifo_clr;
	assign irq_regs_clear_o  = s_r.irq_clr;
	assign set_default_o     = s_r.set_def;
	assign transparent_o     = s_r.transparent;
	assign test_access_o     = s_r.test_access;
	assign gpt_start_o       = s_r.gpt_start;
	assign wut_start_o       = s_r.wut_start;
	assign mrt_start_o       = s_r.mrt_start;
	assign nrt_start_o       = s_r.nrt_start;
	assign gpt_stop_o        = s_r.gpt_stop;
	assign mrt_stop_o        = s_r.mrt_stop;
	assign nrt_stop_o        = s_r.nrt_stop;

endmodule

`default_nettype wire

// File: verification/rdc_properties.sv
// Concurrent checks on the ports of the direct command decoder.
`timescale 1ns/1ps
`default_nettype none

module rdc_properties
	import rdc_pkg::*;
(
	// Clock, reset and inputs
	input wire logic              mclk_i,
	input wire logic              arst_n_i,
	input wire logic [7:0]        reg_addr_i,
	input wire logic [7:0]        reg_wdata_i,
	input wire logic              reg_wr_i,
	input wire logic              cmd_valid_i,
	input wire logic [7:0]        cmd_code_i,
	input wire logic              xtal_stable_i,
	input wire logic [UNIT_N-1:0] unit_done_i,
	// Outputs
	input wire logic              cmd_busy_o,
	input wire logic              cmd_done_irq_o,
	input wire logic [UNIT_N-1:0] unit_start_o,
	input wire logic              fifo_clear_o,
	input wire logic              txrx_abort_o,
	input wire logic              set_default_o,
	input wire logic              cmd_chain_ok_o
);
	// ----------------------------------------
	// Shadow state
	// ----------------------------------------
	logic              en_r;
	logic [UNIT_N-1:0] run_r;
	logic [2:0]        xcnt_r;

	// Tracks the enable bit, the running unit and how long the oscillator is stable.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en_r   <= 1'b0;
			run_r  <= '0;
			xcnt_r <= 3'h0;
		end else begin
			if (reg_wr_i && reg_addr_i == ADDR_OP_CTRL) en_r <= reg_wdata_i[BIT_EN];
			if (unit_start_o != '0) run_r <= unit_start_o;
			xcnt_r <= !xtal_stable_i ? 3'h0 : (xcnt_r == 3'h7 ? xcnt_r : xcnt_r + 3'h1);
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_take(logic [7:0] c);
		cmd_valid_i && cmd_code_i == c && !cmd_busy_o && en_r;
	endsequence
	sequence s_unit_done;
		cmd_busy_o && (unit_done_i & run_r) != '0;
	endsequence
	sequence s_set_default;
		cmd_valid_i && cmd_code_i == CMD_SET_DEFAULT;
	endsequence

	AST_D3_START: assert property (s_take(CMD_MEAS_AMPL) |=> unit_start_o == 8'h01 && cmd_busy_o)
		else $error("amplitude unit not started");
	AST_NO_EN: assert property (cmd_valid_i && !en_r && cmd_code_i == CMD_MEAS_AMPL |=> unit_start_o == '0)
		else $error("unit started without enable");
	AST_DONE: assert property (s_unit_done ##0 !(cmd_valid_i && cmd_code_i == CMD_SET_DEFAULT)
		|=> cmd_done_irq_o && !cmd_busy_o)
		else $error("completion not signalled");
	AST_BUSY_REFUSE: assert property (cmd_busy_o && cmd_valid_i
		&& cmd_code_i != CMD_SET_DEFAULT && (unit_done_i & run_r) == '0 |=> unit_start_o == '0)
		else $error("command taken while busy");
	AST_CLEAR: assert property (cmd_valid_i && !cmd_busy_o && en_r && xcnt_r == 3'h7
		&& (cmd_code_i == CMD_CLEAR_A || cmd_code_i == CMD_CLEAR_B)
		|=> fifo_clear_o && txrx_abort_o && cmd_chain_ok_o)
		else $error("clear had no effect");
	AST_CLEAR_OFF: assert property (cmd_valid_i && !en_r
		&& (cmd_code_i == CMD_CLEAR_A || cmd_code_i == CMD_CLEAR_B)
		|=> !fifo_clear_o && !txrx_abort_o)
		else $error("clear taken without enable");
	AST_SETDEF: assert property (s_set_default |=> set_default_o && !cmd_chain_ok_o
		&& !cmd_busy_o && !cmd_done_irq_o ##1 !cmd_done_irq_o)
		else $error("set default misbehaved");
	AST_SETDEF_FIFO: assert property (s_set_default |=> fifo_clear_o == $past(en_r))
		else $error("set default fifo clear wrong");
	AST_UNUSED: assert property (cmd_valid_i && cmd_code_i == 8'hd2
		|=> unit_start_o == '0 && !fifo_clear_o && !set_default_o && $stable(cmd_chain_ok_o))
		else $error("unused code had an effect");

endmodule

`default_nettype wire

// File: verification/rdc_unit_model.sv
// Behavioural model of the measurement and calibration units.
`timescale 1ns/1ps
`default_nettype none

module rdc_unit_model
	import rdc_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk_i,
	input  wire logic              arst_n_i,
	// Unit handshake
	input  wire logic [UNIT_N-1:0] unit_start_i,
	input  wire logic              slow_i,
	output logic      [UNIT_N-1:0] unit_done_o
);
	logic [UNIT_N-1:0] run_r;
	logic [5:0]        cnt_r;

	// A started unit finishes after a short or long run with a one-cycle done.
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_r       <= '0;
			cnt_r       <= 6'h00;
			unit_done_o <= '0;
		end else begin
			unit_done_o <= '0;
			if (unit_start_i != '0) begin
				run_r <= unit_start_i;
				cnt_r <= slow_i ? 6'h1e : 6'h03;
			end else if (cnt_r != 6'h00) begin
				cnt_r <= cnt_r - 6'h01;
				if (cnt_r == 6'h01) unit_done_o <= run_r;
			end
		end
	end

endmodule

`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench of the direct command decoder.
`timescale 1ns/1ps
`default_nettype none

module tb
	import rdc_pkg::*;
;
	logic              mclk_i = 1'b0;
	logic              arst_n_i = 1'b0;
	logic [7:0]        reg_addr_i = 8'h00;
	logic [7:0]        reg_wdata_i = 8'h00;
	logic              reg_wr_i = 1'b0;
	logic              reg_rd_i = 1'b0;
	logic              cmd_valid_i = 1'b0;
	logic [7:0]        cmd_code_i = 8'h00;
	logic              xtal_stable_i = 1'b0;
	logic [7:0]        noise_level_i = 8'h3c;
	logic              slow = 1'b0;
	logic [UNIT_N-1:0] unit_start_o, unit_done_i;
	logic [7:0]        reg_rdata_o, rx_gain_red_o;
	logic cmd_chain_ok_o, cmd_busy_o, cmd_done_irq_o, tx_activate_o, results_discard_o;
	logic rx_unmask_o, rssi_restart_o, txrx_abort_o, fifo_clear_o, irq_regs_clear_o;
	logic set_default_o, transparent_o, test_access_o, gpt_start_o, wut_start_o;
	logic mrt_start_o, nrt_start_o, gpt_stop_o, mrt_stop_o, nrt_stop_o;
	logic [13:0]       fx;
	int                errors = 0;
	int                n_compared = 0;

	assign fx = {rx_unmask_o, rssi_restart_o, mrt_start_o, gpt_start_o, wut_start_o, nrt_start_o,
		txrx_abort_o, fifo_clear_o, irq_regs_clear_o, gpt_stop_o, mrt_stop_o, nrt_stop_o,
		set_default_o, results_discard_o};

	rdc_decoder DUT (.mclk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .cmd_valid_i, .cmd_code_i, .cmd_chain_ok_o, .cmd_busy_o, .cmd_done_irq_o,
		.xtal_stable_i, .noise_level_i, .unit_start_o, .unit_done_i, .tx_activate_o,
		.results_discard_o, .rx_unmask_o, .rssi_restart_o, .rx_gain_red_o, .txrx_abort_o,
		.fifo_clear_o, .irq_regs_clear_o, .set_default_o, .transparent_o, .test_access_o,
		.gpt_start_o, .wut_start_o, .mrt_start_o, .nrt_start_o, .gpt_stop_o, .mrt_stop_o,
		.nrt_stop_o);
	rdc_unit_model PM (.mclk_i, .arst_n_i, .unit_start_i(unit_start_o), .slow_i(slow),
		.unit_done_o(unit_done_i));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 chk({8'h00, reg_rdata_o}, {8'h00, e});
	endtask
	task automatic cmd(input logic [7:0] c);
		@(posedge mclk_i);
		cmd_valid_i <= 1'b1;
		cmd_code_i <= c;
		@(posedge mclk_i);
		cmd_valid_i <= 1'b0;
		#1;
	endtask
	task automatic wait_irq(output logic hit);
		hit = 1'b0;
		for (int i = 0; i < 60 && hit !== 1'b1; i++) begin
			@(posedge mclk_i);
			#1 hit = cmd_done_irq_o;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_refuse();
		cmd(CMD_MEAS_AMPL);
		chk({8'h00, unit_start_o}, 16'h0000);
		cmd(CMD_CLEAR_A);
		chk({2'b0, fx}, 16'h0000);
		wr(ADDR_OP_CTRL, 8'h80);
		wr(ADDR_REG_CTRL, 8'h80);
		wr(ADDR_CAP_CTRL, 8'h01);
		cmd(CMD_ADJ_REG);
		chk({8'h00, unit_start_o}, 16'h0000);
		cmd(CMD_CAL_CAP);
		chk({8'h00, unit_start_o}, 16'h0000);
		cmd(8'hd2);
		chk({2'b0, fx}, 16'h0000);
		rd(ADDR_STATUS, 8'h18);
		wr(ADDR_REG_CTRL, 8'h00);
		wr(ADDR_CAP_CTRL, 8'h00);
	endtask
	task automatic t_units();
		logic [7:0] codes [8] = '{CMD_MEAS_AMPL, CMD_ADJ_REG, CMD_CAL_MOD, CMD_CAL_ANT,
			CMD_MEAS_PHASE, CMD_CAL_CAP, CMD_MEAS_CAP, CMD_MEAS_SUPPLY};
		logic hit;
		for (int i = 0; i < 8; i++) begin
			cmd(codes[i]);
			chk({8'h00, unit_start_o}, 16'h0001 << i);
			chk({13'h0, cmd_busy_o, cmd_chain_ok_o, tx_activate_o}, {13'h0, 2'b10, 1'(i == 2)});
			wait_irq(hit);
			chk({14'h0, hit, cmd_busy_o}, 16'h0002);
		end
	endtask
	task automatic t_busy();
		logic hit;
		slow = 1'b1;
		cmd(CMD_MEAS_PHASE);
		cmd(CMD_MEAS_AMPL);
		chk({8'h00, unit_start_o}, 16'h0000);
		cmd(CMD_SET_DEFAULT);
		chk({15'h0, cmd_busy_o}, 16'h0000);
		wait_irq(hit);
		chk({15'h0, hit}, 16'h0000);
		slow = 1'b0;
	endtask
	task automatic t_clear();
		wr(ADDR_TMR_CTRL, 8'h00);
		cmd(CMD_CLEAR_A);
		chk({2'b0, fx}, 16'h00fc);
		wr(ADDR_TMR_CTRL, 8'h01);
		cmd(CMD_CLEAR_B);
		chk({2'b0, fx}, 16'h00f8);
		chk({15'h0, cmd_chain_ok_o}, 16'h0001);
	endtask
	task automatic t_simple();
		logic [7:0]  codes [10] = '{CMD_SQUELCH, CMD_RESET_GAIN, CMD_UNMASK_RX, CMD_CLEAR_RSSI,
			CMD_START_GPT, CMD_START_WUT, CMD_START_MRT, CMD_START_NRT, CMD_TRANSPARENT, CMD_TEST_ACCESS};
		logic [13:0] fxe [10] = '{14'h0, 14'h0, 14'h2000, 14'h1000, 14'h0400, 14'h0200, 14'h0800,
			14'h0100, 14'h0, 14'h0};
		logic [9:0]  ch = 10'b1011111100;
		wr(ADDR_OP_CTRL, 8'hc0);
		wr(ADDR_RX_CONF4, 8'h27);
		wr(ADDR_MODE, 8'h01);
		for (int i = 0; i < 10; i++) begin
			cmd(codes[i]);
			chk({2'b0, fx}, {2'b0, fxe[i]});
			chk({15'h0, cmd_chain_ok_o}, {15'h0, ch[i]});
			if (i < 2) chk({8'h00, rx_gain_red_o}, {8'h00, i == 0 ? noise_level_i : 8'h27});
		end
		chk({14'h0, transparent_o, test_access_o}, 16'h0003);
		rd(ADDR_STATUS, 8'h16);
		rd(ADDR_LAST_CMD, CMD_TEST_ACCESS);
	endtask
	task automatic t_setdef();
		for (int a = 1; a < 6; a++) wr(8'(a), 8'h5a);
		cmd(CMD_START_WUT);
		chk({2'b0, fx}, 16'h0000);
		cmd(CMD_START_MRT);
		chk({2'b0, fx}, 16'h0000);
		cmd(CMD_SET_DEFAULT);
		chk({2'b0, fx & 14'h0043}, 16'h0043);
		chk({13'h0, cmd_chain_ok_o, transparent_o, test_access_o}, 16'h0000);
		rd(ADDR_OP_CTRL, 8'hc0);
		for (int a = 1; a < 6; a++) rd(8'(a), 8'h00);
		rd(ADDR_GAIN, 8'h00);
		wr(ADDR_OP_CTRL, 8'h00);
		cmd(CMD_SET_DEFAULT);
		chk({2'b0, fx & 14'h0043}, 16'h0003);
	endtask

	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Clock, sequence and watchdog
	// ----------------------------------------
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		for (int a = 0; a < 9; a++) rd(8'(a), 8'h00);
		rd(8'h20, 8'h00);
		xtal_stable_i <= 1'b1;
		t_refuse();
		t_units();
		t_busy();
		t_clear();
		t_simple();
		t_setdef();
		report_and_stop();
	end
	initial begin
		#1000000;
		errors++;
		report_and_stop();
	end

endmodule

bind rdc_decoder rdc_properties CHK (.mclk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.cmd_valid_i, .cmd_code_i, .xtal_stable_i, .unit_done_i, .cmd_busy_o, .cmd_done_irq_o,
	.unit_start_o, .fifo_clear_o, .txrx_abort_o, .set_default_o, .cmd_chain_ok_o);

`default_nettype wire
